// >>> core/cvb_pkg.sv
// package: register indices, field positions and carriers for the crtc vertical/mode block
package cvb_pkg;
  // ---------------------------------------------------------------
  // register indices
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_VBLANK_START = 8'h15;
  localparam logic [7:0] IDX_VBLANK_END   = 8'h16;
  localparam logic [7:0] IDX_MODE         = 8'h17;
  localparam logic [7:0] IDX_SPLIT_CMP    = 8'h18;
  localparam logic [7:0] IDX_LATCH_RB     = 8'h22;
  localparam logic [7:0] IDX_ATTR_RB_A    = 8'h24;
  localparam logic [7:0] IDX_ATTR_RB_B    = 8'h26;
  // ---------------------------------------------------------------
  // reset values and mode bit positions
  // ---------------------------------------------------------------
  localparam logic [7:0] MODE_RESET       = 8'h00;
  localparam logic [7:0] REG_RESET        = 8'h00;
  localparam int BANK2_SUBSTITUTE_BIT     = 0;
  localparam int BANK4_SUBSTITUTE_BIT     = 1;
  localparam int VERTICAL_CLOCK_HALVE_BIT = 2;
  localparam int WORD_CLOCK_DIVIDE_BIT    = 3;
  localparam int ADDRESS_WRAP_BIT         = 5;
  localparam int WORD_ADDRESSING_BIT      = 6;
  localparam int RETRACE_ENABLE_BIT       = 7;
  // upper-bit sources in neighbour registers
  localparam int OVF_VBS8 = 3;
  localparam int OVF_LC8  = 4;
  localparam int MSL_VBS9 = 5;
  localparam int MSL_LC9  = 6;
  localparam int EXT_VBS10 = 2;
  localparam int EXT_LC10  = 6;
  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] index;
    logic [7:0] wdata;
  } cvb_io_t;

  typedef struct packed {
    logic [7:0] overflow_register;
    logic [7:0] max_scan_line_register;
    logic [7:0] extended_vertical_overflow;
    logic [9:0] row_pitch_register;
    logic [1:0] offset_scale;
  } cvb_ext_t;

  typedef struct packed {
    logic [31:0] cpu_latches;
    logic [1:0]  plane_read_select;
    logic [4:0]  attr_index;
    logic        video_display_enabled;
    logic        attribute_index_toggle;
  } cvb_rb_t;
endpackage

// >>> core/cvb_addr_map.sv
// address output mapping: bank substitution and word addressing
`timescale 1ns/1ps
`default_nettype none
module cvb_addr_map #(
  parameter int AW = 16
) (
  // control
  input  wire logic [7:0]    mode,
  input  wire logic          active,
  input  wire logic [1:0]    row_scan,
  // address
  input  wire logic [AW-1:0] counter,
  output logic      [AW-1:0] mem_addr
);
  import cvb_pkg::*;
  logic [AW-1:0] shaped;

  always_comb begin
    shaped = counter;
    if (!mode[WORD_ADDRESSING_BIT]) begin
      shaped = {1'b0, counter[AW-1:1]};
      shaped[0] = mode[ADDRESS_WRAP_BIT] ? counter[15] : counter[13];
    end
    if (active && !mode[BANK2_SUBSTITUTE_BIT]) begin
      shaped[13] = row_scan[0];
    end
    if (active && !mode[BANK4_SUBSTITUTE_BIT]) begin
      shaped[14] = row_scan[1];
    end
    mem_addr = shaped;
  end
endmodule
`default_nettype wire

// >>> core/cvb_core.sv
// crtc vertical blank, mode control, split screen and readback registers
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - blank start is eleven bits, scan line of blanking minus one, low byte here.
// - start bit 8,9,10 from overflow b3, max scan b5, extended b2.
// - blanking ends when counter low byte equals end value; width up to 256.
// - bank2 bit clear puts row scan bit 0 on address bit 13 while active.
// - bank4 bit clear puts row scan bit 1 on address bit 14 while active.
// - halve bit set advances vertical counter every second retrace clock.
// - word clock bit set advances address counter every second character clock.
// - in word mode wrap bit chooses counter bit 13 or 15 for address bit 0.
// - word addressing shifts counter down one, counter bit 13 or 15 to address bit 0.
// - retrace enable clear holds both retrace pulses inactive.
// - retrace enable clear touches nothing but the retrace pulses.
// - scan line equal to line compare clears address counter to zero.
// - after split each row start adds the row offset to the previous start.
// - compare bit 8,9,10 from overflow b4, max scan b6, extended b6.
// - latch readback is read only, byte chosen by plane read select bits 1-0.
// - attribute readback is read only, same at index 24h and 26h.
// - attribute readback: index 4-0, enable bit 5, zero bit 6, toggle inverted bit 7.
// - row offset scaled by 2, 4 or 8 for word, dword, qword.
module cvb_core #(
  parameter int AW = 16,
  parameter int VW = 11
) (
  // clock and reset
  input  wire logic               core_clk,
  input  wire logic               resetn,
  // indexed register port
  input  wire cvb_pkg::cvb_io_t   io,
  output logic      [7:0]         rdata,
  // neighbour registers and readback sources
  input  wire cvb_pkg::cvb_ext_t  ext,
  input  wire cvb_pkg::cvb_rb_t   rb,
  // timing ticks
  input  wire logic               char_tick,
  input  wire logic               hretrace_tick,
  input  wire logic               frame_start,
  input  wire logic [AW-1:0]      start_address,
  input  wire logic [1:0]         row_scan,
  input  wire logic               row_end,
  input  wire logic               active,
  input  wire logic               hretrace_in,
  input  wire logic               vretrace_in,
  // display outputs
  output logic      [VW-1:0]      scan_line,
  output logic                    vblank,
  output logic                    hretrace_out,
  output logic                    vretrace_out,
  output logic                    split_hit,
  output logic      [AW-1:0]      mem_addr
);
  import cvb_pkg::*;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0]    vblank_start_reg;
  logic [7:0]    vblank_end_reg;
  logic [7:0]    crtc_mode_reg;
  logic [7:0]    split_compare_reg;
  logic          vhalf;
  logic          char_half;
  logic [AW-1:0] addr_cnt;
  logic [AW-1:0] row_start;
  logic          split_seen;
  logic [VW-1:0] vblank_start_full;
  logic [VW-1:0] split_full;
  logic [AW-1:0] row_step;
  logic          v_adv;
  logic          a_adv;
  logic [7:0]    latch_byte;
  logic [7:0]    attr_byte;
  logic          next_vblank;

  function automatic logic is_attr_index(input logic [7:0] idx);
    is_attr_index = (idx == IDX_ATTR_RB_A) || (idx == IDX_ATTR_RB_B);
  endfunction

  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------
  // readback indices have no storage, so writes there fall away
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      vblank_start_reg  <= REG_RESET;
      vblank_end_reg    <= REG_RESET;
      crtc_mode_reg     <= MODE_RESET;
      split_compare_reg <= REG_RESET;
    end else if (io.wr) begin
      case (io.index)
        IDX_VBLANK_START: vblank_start_reg  <= io.wdata;
        IDX_VBLANK_END:   vblank_end_reg    <= io.wdata;
        IDX_MODE:         crtc_mode_reg     <= {io.wdata[7:5], 1'b0, io.wdata[3:0]};
        IDX_SPLIT_CMP:    split_compare_reg <= io.wdata;
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // readback
  // ---------------------------------------------------------------
  always_comb begin
    latch_byte = rb.cpu_latches[8*rb.plane_read_select +: 8];
    attr_byte  = {~rb.attribute_index_toggle, 1'b0,
                  rb.video_display_enabled, rb.attr_index};
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rdata <= 8'h00;
    end else if (io.rd) begin
      if (is_attr_index(io.index)) begin
        rdata <= attr_byte;
      end else begin
        case (io.index)
          IDX_VBLANK_START: rdata <= vblank_start_reg;
          IDX_VBLANK_END:   rdata <= vblank_end_reg;
          IDX_MODE:         rdata <= crtc_mode_reg;
          IDX_SPLIT_CMP:    rdata <= split_compare_reg;
          IDX_LATCH_RB:     rdata <= latch_byte;
          default:          rdata <= 8'h00;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // eleven-bit compare values
  // ---------------------------------------------------------------
  always_comb begin
    vblank_start_full = {ext.extended_vertical_overflow[EXT_VBS10],
                         ext.max_scan_line_register[MSL_VBS9],
                         ext.overflow_register[OVF_VBS8],
                         vblank_start_reg};
    split_full        = {ext.extended_vertical_overflow[EXT_LC10],
                         ext.max_scan_line_register[MSL_LC9],
                         ext.overflow_register[OVF_LC8],
                         split_compare_reg};
  end

  // ---------------------------------------------------------------
  // vertical counter
  // ---------------------------------------------------------------
  // halving only drops every other retrace tick
  assign v_adv = hretrace_tick && (!crtc_mode_reg[VERTICAL_CLOCK_HALVE_BIT] || vhalf);

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      vhalf <= 1'b0;
    end else if (frame_start) begin
      vhalf <= 1'b0;
    end else if (hretrace_tick) begin
      vhalf <= ~vhalf;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      scan_line <= '0;
    end else if (frame_start) begin
      scan_line <= '0;
    end else if (v_adv) begin
      scan_line <= scan_line + VW'(1);
    end
  end

  // ---------------------------------------------------------------
  // vertical blank
  // ---------------------------------------------------------------
  // blank rises on the line after start (value is line minus one)
  always_comb begin
    next_vblank = vblank;
    if (v_adv && scan_line == vblank_start_full) begin
      next_vblank = 1'b1;
    end
    if (v_adv && (scan_line[7:0] + 8'h01) == vblank_end_reg && vblank) begin
      next_vblank = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      vblank <= 1'b0;
    end else begin
      vblank <= next_vblank;
    end
  end

  // ---------------------------------------------------------------
  // retrace gating; only these two flops see the enable
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      hretrace_out <= 1'b0;
      vretrace_out <= 1'b0;
    end else begin
      hretrace_out <= hretrace_in && crtc_mode_reg[RETRACE_ENABLE_BIT];
      vretrace_out <= vretrace_in && crtc_mode_reg[RETRACE_ENABLE_BIT];
    end
  end

  // ---------------------------------------------------------------
  // address counter
  // ---------------------------------------------------------------
  assign a_adv = char_tick && (!crtc_mode_reg[WORD_CLOCK_DIVIDE_BIT] || char_half);
  assign split_hit = (scan_line == split_full);

  always_comb begin
    case (ext.offset_scale)
      2'd1:    row_step = AW'({ext.row_pitch_register, 2'b00});
      2'd2:    row_step = AW'({ext.row_pitch_register, 3'b000});
      default: row_step = AW'({ext.row_pitch_register, 1'b0});
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      char_half <= 1'b0;
    end else if (row_end) begin
      char_half <= 1'b0;
    end else if (char_tick) begin
      char_half <= ~char_half;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      split_seen <= 1'b0;
      row_start  <= '0;
      addr_cnt   <= '0;
    end else if (frame_start) begin
      split_seen <= 1'b0;
      row_start  <= start_address;
      addr_cnt   <= start_address;
    end else if (split_hit && !split_seen) begin
      split_seen <= 1'b1;
      row_start  <= '0;
      addr_cnt   <= '0;
    end else if (row_end) begin
      row_start <= row_start + row_step;
      addr_cnt  <= row_start + row_step;
    end else if (a_adv) begin
      addr_cnt <= addr_cnt + AW'(1);
    end
  end

  // ---------------------------------------------------------------
  // output address shaping
  // ---------------------------------------------------------------
  cvb_addr_map #(
    .AW(AW)
  ) cvb_addr_map_i (
    .mode     (crtc_mode_reg),
    .active   (active),
    .row_scan (row_scan),
    .counter  (addr_cnt),
    .mem_addr (mem_addr)
  );

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  chk_retrace_gate: assert property (@(posedge core_clk) disable iff (!resetn)
    !$past(crtc_mode_reg[RETRACE_ENABLE_BIT]) |-> !vretrace_out && !hretrace_out)
    else $error("retrace pulse while disabled");
  chk_retrace_pass: assert property (@(posedge core_clk) disable iff (!resetn)
    $past(crtc_mode_reg[RETRACE_ENABLE_BIT])
      |-> hretrace_out == $past(hretrace_in) && vretrace_out == $past(vretrace_in))
    else $error("retrace pulse not passed while enabled");
  chk_split_clear: assert property (@(posedge core_clk) disable iff (!resetn)
    split_hit && !split_seen && !frame_start |=> addr_cnt == '0)
    else $error("split did not clear counter");
  chk_row_advance: assert property (@(posedge core_clk) disable iff (!resetn)
    row_end && !frame_start && !(split_hit && !split_seen)
      |=> row_start == $past(row_start) + $past(row_step))
    else $error("row start not advanced by offset");
  chk_row_double: assert property (@(posedge core_clk) disable iff (!resetn)
    ext.offset_scale == 2'd0 |-> row_step == AW'({ext.row_pitch_register, 1'b0}))
    else $error("word pitch not doubled");
  chk_row_octuple: assert property (@(posedge core_clk) disable iff (!resetn)
    ext.offset_scale[1] |-> row_step == AW'({ext.row_pitch_register, 3'b000}))
    else $error("quadword pitch not scaled by eight");
  chk_blank_start: assert property (@(posedge core_clk) disable iff (!resetn)
    v_adv && scan_line == vblank_start_full && !frame_start
      && (scan_line[7:0] + 8'h01) != vblank_end_reg |=> vblank)
    else $error("blank did not start");
  chk_blank_rise: assert property (@(posedge core_clk) disable iff (!resetn)
    $rose(vblank) |-> $past(v_adv) && $past(scan_line) == $past(vblank_start_full))
    else $error("blank rose away from start line");
  chk_blank_end: assert property (@(posedge core_clk) disable iff (!resetn)
    vblank && v_adv && (scan_line[7:0] + 8'h01) == vblank_end_reg |=> !vblank)
    else $error("blank did not end");
  chk_scan_step: assert property (@(posedge core_clk) disable iff (!resetn)
    v_adv && !frame_start |=> scan_line == $past(scan_line) + VW'(1))
    else $error("vertical counter missed an advance");
  chk_vhalf_hold: assert property (@(posedge core_clk) disable iff (!resetn)
    crtc_mode_reg[VERTICAL_CLOCK_HALVE_BIT] && hretrace_tick && !vhalf && !frame_start
      |=> scan_line == $past(scan_line))
    else $error("vertical counter advanced on skipped tick");
  chk_word_hold: assert property (@(posedge core_clk) disable iff (!resetn)
    crtc_mode_reg[WORD_CLOCK_DIVIDE_BIT] && char_tick && !char_half && !frame_start
      && !row_end && !(split_hit && !split_seen) |=> addr_cnt == $past(addr_cnt))
    else $error("address advanced on skipped character");
  chk_bank2_sub: assert property (@(posedge core_clk) disable iff (!resetn)
    active && !crtc_mode_reg[BANK2_SUBSTITUTE_BIT] |-> mem_addr[13] == row_scan[0])
    else $error("bank2 substitution missing");
  chk_bank4_sub: assert property (@(posedge core_clk) disable iff (!resetn)
    active && !crtc_mode_reg[BANK4_SUBSTITUTE_BIT] |-> mem_addr[14] == row_scan[1])
    else $error("bank4 substitution missing");
  // shaping judged outside active display, where no bank bit interferes
  chk_word_shift: assert property (@(posedge core_clk) disable iff (!resetn)
    !crtc_mode_reg[WORD_ADDRESSING_BIT] && !active
      |-> mem_addr[AW-1:1] == {1'b0, addr_cnt[AW-1:2]})
    else $error("word mode shift wrong");
  chk_wrap_select: assert property (@(posedge core_clk) disable iff (!resetn)
    !crtc_mode_reg[WORD_ADDRESSING_BIT] && !active
      |-> mem_addr[0] == (crtc_mode_reg[ADDRESS_WRAP_BIT] ? addr_cnt[15] : addr_cnt[13]))
    else $error("word mode wrap on wrong counter bit");
  chk_byte_pass: assert property (@(posedge core_clk) disable iff (!resetn)
    crtc_mode_reg[WORD_ADDRESSING_BIT] && !active |-> mem_addr == addr_cnt)
    else $error("byte mode address altered");
  chk_latch_pick: assert property (@(posedge core_clk) disable iff (!resetn)
    io.rd && io.index == IDX_LATCH_RB |=> rdata == $past(latch_byte))
    else $error("latch readback byte wrong");
  chk_rb_no_store: assert property (@(posedge core_clk) disable iff (!resetn)
    io.wr && (io.index == IDX_LATCH_RB || is_attr_index(io.index))
      |=> $stable(crtc_mode_reg) && $stable(split_compare_reg)
        && $stable(vblank_start_reg) && $stable(vblank_end_reg))
    else $error("readback write changed a register");
  chk_attr_alias: assert property (@(posedge core_clk) disable iff (!resetn)
    io.rd && is_attr_index(io.index)
      |=> rdata[6] == 1'b0 && rdata[7] == !$past(rb.attribute_index_toggle))
    else $error("attribute readback wrong");
  chk_attr_fields: assert property (@(posedge core_clk) disable iff (!resetn)
    io.rd && is_attr_index(io.index)
      |=> rdata[5:0] == {$past(rb.video_display_enabled), $past(rb.attr_index)})
    else $error("attribute index or enable bits wrong");
endmodule
`default_nettype wire

// >>> dv/cvb_timing_model.sv
// far-side model: character, retrace, row and frame pulses for the core
`timescale 1ns/1ps
`default_nettype none
module cvb_timing_model (
  // clock
  input  wire logic core_clk,
  // timing pulses
  output logic      char_tick,
  output logic      hretrace_tick,
  output logic      frame_start,
  output logic      row_end
);
  initial begin
    {char_tick, hretrace_tick, frame_start, row_end} = 4'h0;
  end
  // ----
  // one pulse, then gap idle cycles (gap lets the line run slowly)
  // ----
  task automatic pulse(input int kind, input int gap);
    @(posedge core_clk);
    case (kind)
      0: frame_start <= 1'b1;
      1: hretrace_tick <= 1'b1;
      2: row_end <= 1'b1;
      default: char_tick <= 1'b1;
    endcase
    @(posedge core_clk);
    {char_tick, hretrace_tick, frame_start, row_end} <= 4'h0;
    repeat (gap) @(posedge core_clk);
    // land after the edge so callers see settled outputs
    #1;
  endtask
endmodule
`default_nettype wire

// >>> dv/crtc_vblank_mode_split_readback_bench.sv
// self-checking bench for the vertical blank, mode, split and readback core
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module crtc_vblank_mode_split_readback_bench;
  import cvb_pkg::*;
  logic        core_clk;
  logic        resetn;
  cvb_io_t     io;
  cvb_ext_t    ext;
  cvb_rb_t     rb;
  logic [15:0] start_address;
  logic [1:0]  row_scan;
  logic        active;
  logic        hretrace_in;
  logic        vretrace_in;
  logic        char_tick;
  logic        hretrace_tick;
  logic        frame_start;
  logic        row_end;
  logic [7:0]  rdata;
  logic [10:0] scan_line;
  logic        vblank;
  logic        hretrace_out;
  logic        vretrace_out;
  logic        split_hit;
  logic [15:0] mem_addr;
  int          mismatches;
  int          n_checks;
  cvb_core #(.AW(16), .VW(11)) cvb_core_i (.core_clk, .resetn, .io, .rdata, .ext, .rb,
    .char_tick, .hretrace_tick, .frame_start, .start_address, .row_scan, .row_end,
    .active, .hretrace_in, .vretrace_in, .scan_line, .vblank, .hretrace_out,
    .vretrace_out, .split_hit, .mem_addr);
  cvb_timing_model cvb_timing_model_i (.core_clk, .char_tick, .hretrace_tick,
    .frame_start, .row_end);
  initial core_clk = 1'b0;
  always #5 core_clk = ~core_clk;
  // ----
  // register port and helpers
  // ----
  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic reg_wr(input logic [7:0] idx, input logic [7:0] d);
    @(posedge core_clk);
    io.wr <= 1'b1;
    io.index <= idx;
    io.wdata <= d;
    @(posedge core_clk);
    io.wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] idx, input logic [7:0] exp);
    @(posedge core_clk);
    io.rd <= 1'b1;
    io.index <= idx;
    @(posedge core_clk);
    io.rd <= 1'b0;
    #1;
    `CHK(rdata, exp)
  endtask
  task automatic conclude();
    $display("checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_regs();
    `CHK(vblank, 1'b0)
    reg_rd(IDX_MODE, 8'h00);
    reg_wr(IDX_VBLANK_START, 8'hA5);
    reg_wr(IDX_VBLANK_END, 8'h5A);
    reg_wr(IDX_SPLIT_CMP, 8'h3C);
    reg_wr(IDX_MODE, 8'hFF);
    reg_rd(IDX_VBLANK_START, 8'hA5);
    reg_rd(IDX_VBLANK_END, 8'h5A);
    reg_rd(IDX_SPLIT_CMP, 8'h3C);
    reg_rd(IDX_MODE, 8'hEF);
    reg_rd(8'h30, 8'h00);
    $display("regs done");
  endtask
  task automatic t_readback();
    rb.cpu_latches <= 32'h44332211;
    rb.attr_index <= 5'h15;
    rb.video_display_enabled <= 1'b1;
    rb.attribute_index_toggle <= 1'b0;
    reg_wr(IDX_LATCH_RB, 8'h00);
    for (int p = 0; p < 4; p++) begin
      rb.plane_read_select <= 2'(p);
      reg_rd(IDX_LATCH_RB, 8'(8'h11 * (p + 1)));
    end
    reg_wr(IDX_ATTR_RB_A, 8'h00);
    reg_rd(IDX_ATTR_RB_A, 8'hB5);
    reg_rd(IDX_ATTR_RB_B, 8'hB5);
    rb.video_display_enabled <= 1'b0;
    rb.attribute_index_toggle <= 1'b1;
    reg_rd(IDX_ATTR_RB_B, 8'h15);
    $display("readback done");
  endtask
  task automatic t_retrace();
    hretrace_in <= 1'b1;
    vretrace_in <= 1'b1;
    reg_wr(IDX_MODE, 8'h00);
    settle(3);
    `CHK({hretrace_out, vretrace_out}, 2'b00)
    reg_wr(IDX_MODE, 8'h80);
    settle(2);
    `CHK({hretrace_out, vretrace_out}, 2'b11)
    reg_wr(IDX_MODE, 8'h00);
    settle(2);
    `CHK({hretrace_out, vretrace_out}, 2'b00)
    reg_rd(IDX_VBLANK_START, 8'hA5);
    reg_rd(IDX_SPLIT_CMP, 8'h3C);
    hretrace_in <= 1'b0;
    vretrace_in <= 1'b0;
    $display("retrace done");
  endtask
  task automatic t_addr_map();
    logic [15:0] c;
    c = start_address;
    reg_wr(IDX_MODE, 8'hC3);
    cvb_timing_model_i.pulse(0, 0);
    `CHK(mem_addr, c)
    reg_wr(IDX_MODE, 8'hC0);
    active <= 1'b1;
    row_scan <= 2'b10;
    settle(1);
    `CHK(mem_addr, {c[15], 2'b10, c[12:0]})
    active <= 1'b0;
    settle(1);
    `CHK(mem_addr, c)
    reg_wr(IDX_MODE, 8'h83);
    settle(0);
    `CHK(mem_addr, {1'b0, c[15:2], c[13]})
    reg_wr(IDX_MODE, 8'hA3);
    settle(0);
    `CHK(mem_addr, {1'b0, c[15:2], c[15]})
    $display("addr map done");
  endtask
  task automatic t_vblank();
    reg_wr(IDX_MODE, 8'h80);
    reg_wr(IDX_VBLANK_START, 8'h03);
    reg_wr(IDX_VBLANK_END, 8'h06);
    cvb_timing_model_i.pulse(0, 0);
    for (int i = 1; i <= 8; i++) begin
      cvb_timing_model_i.pulse(1, 1);
      `CHK(scan_line, 11'(i))
      `CHK(vblank, 1'(i >= 4 && i < 6))
    end
    ext.overflow_register[OVF_VBS8] <= 1'b1;
    cvb_timing_model_i.pulse(0, 0);
    for (int i = 1; i <= 8; i++) begin
      cvb_timing_model_i.pulse(1, 0);
      `CHK(vblank, 1'b0)
    end
    ext.overflow_register[OVF_VBS8] <= 1'b0;
    reg_wr(IDX_MODE, 8'h84);
    cvb_timing_model_i.pulse(0, 0);
    for (int i = 1; i <= 4; i++) begin
      cvb_timing_model_i.pulse(1, 0);
      `CHK(scan_line, 11'(i / 2))
    end
    $display("vblank done");
  endtask
  task automatic t_split();
    ext.row_pitch_register <= 10'h123;
    ext.offset_scale <= 2'h0;
    ext.overflow_register[OVF_LC8] <= 1'b1;
    reg_wr(IDX_SPLIT_CMP, 8'h02);
    reg_wr(IDX_MODE, 8'hC3);
    cvb_timing_model_i.pulse(0, 0);
    cvb_timing_model_i.pulse(1, 0);
    cvb_timing_model_i.pulse(1, 0);
    `CHK(split_hit, 1'b0)
    `CHK(mem_addr, start_address)
    ext.overflow_register[OVF_LC8] <= 1'b0;
    settle(1);
    `CHK(split_hit, 1'b1)
    `CHK(mem_addr, 16'h0000)
    cvb_timing_model_i.pulse(2, 0);
    `CHK(mem_addr, 16'h0246)
    ext.offset_scale <= 2'h1;
    cvb_timing_model_i.pulse(2, 0);
    `CHK(mem_addr, 16'h06D2)
    ext.offset_scale <= 2'h2;
    cvb_timing_model_i.pulse(2, 0);
    `CHK(mem_addr, 16'h0FEA)
    cvb_timing_model_i.pulse(3, 0);
    `CHK(mem_addr, 16'h0FEB)
    reg_wr(IDX_MODE, 8'hCB);
    cvb_timing_model_i.pulse(2, 0);
    `CHK(mem_addr, 16'h1902)
    cvb_timing_model_i.pulse(3, 0);
    cvb_timing_model_i.pulse(3, 0);
    `CHK(mem_addr, 16'h1903)
    $display("split done");
  endtask
  initial begin
    resetn = 1'b0;
    io = '0;
    ext = '0;
    rb = '0;
    start_address = 16'hA5C3;
    row_scan = 2'h0;
    active = 1'b0;
    hretrace_in = 1'b0;
    vretrace_in = 1'b0;
    mismatches = 0;
    n_checks = 0;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    t_regs();
    t_readback();
    t_retrace();
    t_addr_map();
    t_vblank();
    t_split();
    conclude();
  end
  // guard against a hang in any scenario
  initial begin
    #500000;
    mismatches++;
    conclude();
  end
endmodule
`default_nettype wire
